//--- plock_params.svh
// constants for the pll lock status and reference clock output block
// Operation
// - lock status reads bit 0: one when locked, zero when unlocked
// - lock needs a live input clock, valid configuration and enable set
// - lock stays low until the loop has settled to a stable period
// - output control stays pending until enable goes from zero to one
// - rate field 00 gives predivider rate, 01 gives twice that rate
// - rate field 10 gives four times, 11 gives eight times the rate
// - output enable one drives the pin, zero leaves it undriven
// - enable zero stops the pll clock and idles dependent clocks
// - predivider scales master clock toward the nominal pll input
`ifndef PLOCK_PARAMS_SVH
`define PLOCK_PARAMS_SVH

`define PLOCK_ADDR_W            16
`define PLOCK_DATA_W            16
`define PLOCK_ADDR_CONFIG_A     16'hf000
`define PLOCK_ADDR_CONFIG_B     16'hf001
`define PLOCK_ADDR_SOURCE       16'hf002
`define PLOCK_ADDR_ENABLE       16'hf003
`define PLOCK_ADDR_LOCK         16'hf004
`define PLOCK_ADDR_OUTCTL       16'hf005

`define PLOCK_RESET_WORD        16'h0000
`define PLOCK_LOCK_BIT          0
`define PLOCK_ENABLE_BIT        0
`define PLOCK_SOURCE_BIT        0
`define PLOCK_OUT_EN_BIT        0
`define PLOCK_RATE_LSB          1
`define PLOCK_RATE_MSB          2
`define PLOCK_DIV_LSB           0
`define PLOCK_DIV_MSB           1

`define PLOCK_NOMINAL_IN_KHZ    3072
`define PLOCK_CLK_PERIOD_NS     10
`define PLOCK_MISSING_EDGE_NS   10000
`define PLOCK_MISSING_EDGE_CYC  (`PLOCK_MISSING_EDGE_NS / `PLOCK_CLK_PERIOD_NS)
`define PLOCK_LOCK_PERIODS      16

`endif

//--- plock_pkg.sv
// types shared by the pll lock and reference clock output block
package plock_pkg;
    typedef enum logic [2:0] {
        PLOCK_IDLE    = 3'b001,
        PLOCK_ACQUIRE = 3'b010,
        PLOCK_LOCKED  = 3'b100
    } plock_state_t;

    typedef logic [1:0]  plock_rate_t;
    typedef logic [15:0] plock_word_t;
endpackage : plock_pkg

//--- plock_core.sv
// pll lock status, predivider and reference clock output logic
`timescale 1ns/1ps
`include "plock_params.svh"

module plock_core (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic [`PLOCK_ADDR_W-1:0]  reg_addr,
    input  wire logic [`PLOCK_DATA_W-1:0]  reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [`PLOCK_DATA_W-1:0]  reg_rdata,
    input  wire logic                      master_clock_input_pin,
    output logic                           ref_output_pin_out,
    output logic                           ref_output_pin_oe,
    output logic                           core_clock_source_select,
    output logic                           pll_clock_running,
    output logic                           pll_locked
);

    localparam logic [15:0] MISS_CYC =
        16'(`PLOCK_MISSING_EDGE_CYC);
    localparam logic [4:0]  LOCK_PERIODS = 5'(`PLOCK_LOCK_PERIODS);

    // predivider terminal count for divide by 1, 2, 4 or 8
    function automatic logic [2:0] div_limit(input logic [1:0] code);
        logic [2:0] lim;
        lim = 3'h0;
        unique case (code)
            2'h0: lim = 3'h0;
            2'h1: lim = 3'h1;
            2'h2: lim = 3'h3;
            2'h3: lim = 3'h7;
        endcase
        return lim;
    endfunction : div_limit

    // half output period in core cycles for rate 1x, 2x, 4x, 8x
    function automatic logic [15:0] half_of(input logic [15:0] p,
                                            input plock_pkg::plock_rate_t r);
        logic [15:0] h;
        h = 16'h0000;
        unique case (r)
            2'h0: h = p >> 1;
            2'h1: h = p >> 2;
            2'h2: h = p >> 3;
            2'h3: h = p >> 4;
        endcase
        if (h == 16'h0000) begin
            h = 16'h0001;
        end
        return h;
    endfunction : half_of

    // two periods agree within one core cycle
    function automatic logic close(input logic [15:0] a,
                                   input logic [15:0] b);
        logic [15:0] d;
        d = (a > b) ? (a - b) : (b - a);
        return d <= 16'h0001;
    endfunction : close

    plock_pkg::plock_word_t  config_a_reg;
    logic [1:0]              config_b_div_reg;
    logic                    source_reg;
    logic                    enable_reg;
    logic [2:0]              outctl_pend_reg;
    logic [1:0]              act_div_reg;
    logic                    act_source_reg;
    logic                    act_valid_reg;
    plock_pkg::plock_rate_t  act_rate_reg;
    logic                    act_out_en_reg;
    logic                    mclk_prev_reg;
    logic [2:0]              pre_cnt_reg;
    logic [15:0]             per_cnt_reg;
    logic [15:0]             period_reg;
    logic [15:0]             gap_cnt_reg;
    logic [4:0]              stable_cnt_reg;
    logic [4:0]              stable_cnt_next;
    plock_pkg::plock_state_t state_reg;
    plock_pkg::plock_state_t state_next;
    logic [15:0]             out_cnt_reg;
    logic                    pin_reg;
    logic                    oe_reg;
    logic [`PLOCK_DATA_W-1:0] rdata_reg;

    logic wr_enable;
    logic disable_wr;
    logic enable_rise;
    logic mclk_rise;
    logic pre_tick;
    logic clock_lost;
    logic period_ok;
    logic [15:0] new_period;
    logic [15:0] half_period;

    assign wr_enable   = reg_write && (reg_addr == `PLOCK_ADDR_ENABLE);
    assign disable_wr  = wr_enable && !reg_wdata[`PLOCK_ENABLE_BIT];
    assign enable_rise = wr_enable && reg_wdata[`PLOCK_ENABLE_BIT]
                         && !enable_reg;
    assign mclk_rise   = master_clock_input_pin && !mclk_prev_reg;
    assign pre_tick    = enable_reg && mclk_rise
                         && (pre_cnt_reg == div_limit(act_div_reg));
    assign clock_lost  = (gap_cnt_reg >= MISS_CYC);
    assign new_period  = per_cnt_reg + 16'h0001;
    assign period_ok   = close(new_period, period_reg);
    assign half_period = half_of(period_reg, act_rate_reg);

    // software configuration registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            config_a_reg     <= `PLOCK_RESET_WORD;
            config_b_div_reg <= 2'h0;
            source_reg       <= 1'b0;
            enable_reg       <= 1'b0;
            outctl_pend_reg  <= 3'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                `PLOCK_ADDR_CONFIG_A: config_a_reg <= reg_wdata;
                `PLOCK_ADDR_CONFIG_B: config_b_div_reg <=
                    reg_wdata[`PLOCK_DIV_MSB:`PLOCK_DIV_LSB];
                `PLOCK_ADDR_SOURCE: source_reg <=
                    reg_wdata[`PLOCK_SOURCE_BIT];
                `PLOCK_ADDR_ENABLE: enable_reg <=
                    reg_wdata[`PLOCK_ENABLE_BIT];
                `PLOCK_ADDR_OUTCTL: outctl_pend_reg <=
                    reg_wdata[`PLOCK_RATE_MSB:0];
                default: ;
            endcase
        end
    end

    // settings become active only on enable rising
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            act_div_reg    <= 2'h0;
            act_source_reg <= 1'b0;
            act_valid_reg  <= 1'b0;
            act_rate_reg   <= 2'h0;
            act_out_en_reg <= 1'b0;
        end else if (enable_rise) begin
            act_div_reg    <= config_b_div_reg;
            act_source_reg <= source_reg;
            act_valid_reg  <= (config_a_reg != `PLOCK_RESET_WORD);
            act_rate_reg   <= outctl_pend_reg[`PLOCK_RATE_MSB:
                                              `PLOCK_RATE_LSB];
            act_out_en_reg <= outctl_pend_reg[`PLOCK_OUT_EN_BIT];
        end
    end

    // master clock edge detect and missing edge watch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mclk_prev_reg <= 1'b0;
            gap_cnt_reg   <= 16'h0000;
        end else begin
            mclk_prev_reg <= master_clock_input_pin;
            if (mclk_rise) begin
                gap_cnt_reg <= 16'h0000;
            end else if (!clock_lost) begin
                gap_cnt_reg <= gap_cnt_reg + 16'h0001;
            end
        end
    end

    // predivider of the master clock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pre_cnt_reg <= 3'h0;
        end else if (!enable_reg) begin
            pre_cnt_reg <= 3'h0;
        end else if (pre_tick) begin
            pre_cnt_reg <= 3'h0;
        end else if (mclk_rise) begin
            pre_cnt_reg <= pre_cnt_reg + 3'h1;
        end
    end

    // predivided period in core cycles
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            per_cnt_reg <= 16'h0000;
            period_reg  <= 16'h0000;
        end else if (!enable_reg || clock_lost) begin
            per_cnt_reg <= 16'h0000;
            period_reg  <= 16'h0000;
        end else if (pre_tick) begin
            per_cnt_reg <= 16'h0000;
            period_reg  <= new_period;
        end else if (per_cnt_reg != 16'hffff) begin
            per_cnt_reg <= per_cnt_reg + 16'h0001;
        end
    end

    // lock acquisition
    always_comb begin
        state_next      = state_reg;
        stable_cnt_next = stable_cnt_reg;
        unique case (state_reg)
            plock_pkg::PLOCK_IDLE: begin
                stable_cnt_next = 5'h00;
                if (enable_reg && act_valid_reg && !clock_lost) begin
                    state_next = plock_pkg::PLOCK_ACQUIRE;
                end
            end
            plock_pkg::PLOCK_ACQUIRE: begin
                if (clock_lost) begin
                    stable_cnt_next = 5'h00;
                end else if (pre_tick) begin
                    if (!period_ok) begin
                        stable_cnt_next = 5'h00;
                    end else if (stable_cnt_reg + 5'h01 >= LOCK_PERIODS) begin
                        state_next = plock_pkg::PLOCK_LOCKED;
                    end else begin
                        stable_cnt_next = stable_cnt_reg + 5'h01;
                    end
                end
            end
            plock_pkg::PLOCK_LOCKED: begin
                stable_cnt_next = 5'h00;
                if (clock_lost || (pre_tick && !period_ok)) begin
                    state_next = plock_pkg::PLOCK_ACQUIRE;
                end
            end
        endcase
        if (!enable_reg || !act_valid_reg || disable_wr) begin
            state_next      = plock_pkg::PLOCK_IDLE;
            stable_cnt_next = 5'h00;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg      <= plock_pkg::PLOCK_IDLE;
            stable_cnt_reg <= 5'h00;
        end else begin
            state_reg      <= state_next;
            stable_cnt_reg <= stable_cnt_next;
        end
    end

    // reference clock synthesis from the locked period
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_cnt_reg <= 16'h0000;
            pin_reg     <= 1'b0;
        end else if (state_reg != plock_pkg::PLOCK_LOCKED) begin
            out_cnt_reg <= 16'h0000;
            pin_reg     <= 1'b0;
        end else if (out_cnt_reg + 16'h0001 >= half_period) begin
            out_cnt_reg <= 16'h0000;
            pin_reg     <= !pin_reg;
        end else begin
            out_cnt_reg <= out_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= act_out_en_reg;
        end
    end

    // register read port, data one cycle after strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= `PLOCK_RESET_WORD;
        end else if (reg_read) begin
            unique case (reg_addr)
                `PLOCK_ADDR_CONFIG_A: rdata_reg <= config_a_reg;
                `PLOCK_ADDR_CONFIG_B: rdata_reg <= {14'h0000,
                                                    config_b_div_reg};
                `PLOCK_ADDR_SOURCE:   rdata_reg <= {15'h0000, source_reg};
                `PLOCK_ADDR_ENABLE:   rdata_reg <= {15'h0000, enable_reg};
                `PLOCK_ADDR_LOCK:     rdata_reg <= {15'h0000,
                    state_reg == plock_pkg::PLOCK_LOCKED};
                `PLOCK_ADDR_OUTCTL:   rdata_reg <= {13'h0000,
                                                    outctl_pend_reg};
                default:              rdata_reg <= `PLOCK_RESET_WORD;
            endcase
        end else begin
            rdata_reg <= `PLOCK_RESET_WORD;
        end
    end

    assign reg_rdata                = rdata_reg;
    assign ref_output_pin_out       = pin_reg;
    assign ref_output_pin_oe        = oe_reg;
    assign core_clock_source_select = act_source_reg;
    assign pll_clock_running        = pll_running(enable_reg,
                                                  act_valid_reg);
    assign pll_locked               = (state_reg == plock_pkg::PLOCK_LOCKED);

    // pll considered running whenever enabled with valid settings
    function automatic logic pll_running(input logic en,
                                         input logic valid);
        return en && valid;
    endfunction : pll_running

endmodule : plock_core

//--- plock_core_sva.sv
// assertions for the pll lock and reference clock output block
`timescale 1ns/1ps
`include "plock_params.svh"

module plock_sva (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        master_clock_input_pin,
    input wire logic        ref_output_pin_out,
    input wire logic        ref_output_pin_oe,
    input wire logic        core_clock_source_select,
    input wire logic        pll_clock_running,
    input wire logic        pll_locked
);
    logic [10:0] quiet_reg;
    logic        mclk_q_reg;

    // cycles since the last master clock rising edge, saturating
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            quiet_reg  <= 11'h000;
            mclk_q_reg <= 1'b0;
        end else begin
            mclk_q_reg <= master_clock_input_pin;
            if (master_clock_input_pin && !mclk_q_reg)
                quiet_reg <= 11'h000;
            else if (quiet_reg != 11'h7ff)
                quiet_reg <= quiet_reg + 11'h001;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_lock_word: assert property ($past(reg_read) &&
        $past(reg_addr) == `PLOCK_ADDR_LOCK |-> reg_rdata[15:1] == 15'h0000 &&
        (reg_rdata[0] == pll_locked || reg_rdata[0] == $past(pll_locked)))
        else $error("lock word does not match lock flag");
    a_lock_running: assert property (pll_locked |-> pll_clock_running)
        else $error("locked without a running pll");
    a_pin_quiet: assert property (!pll_locked [*2] |-> !ref_output_pin_out)
        else $error("output pin toggles while unlocked");
    a_oe_pending: assert property ($changed(ref_output_pin_oe) |->
        $past(reg_write, 2) && $past(reg_addr, 2) == `PLOCK_ADDR_ENABLE &&
        $past(reg_wdata[0], 2))
        else $error("output enable changed without enable rise");
    a_src_pending: assert property ($changed(core_clock_source_select) |->
        $past(reg_write) && $past(reg_addr) == `PLOCK_ADDR_ENABLE &&
        $past(reg_wdata[0]))
        else $error("source select changed without enable rise");
    a_disable_idle: assert property (reg_write &&
        reg_addr == `PLOCK_ADDR_ENABLE && !reg_wdata[0]
        |=> !pll_locked && !pll_clock_running)
        else $error("disable did not stop pll and clear lock");
    a_lost_input: assert property (quiet_reg > 11'h3fc |-> !pll_locked)
        else $error("lock held without master clock");

    c_locked_out: cover property (pll_locked && ref_output_pin_oe);
    c_lock_lost: cover property ($fell(pll_locked));
    c_oe_rise: cover property ($rose(ref_output_pin_oe));
endmodule : plock_sva

bind plock_core plock_sva u_sva (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .master_clock_input_pin(master_clock_input_pin),
    .ref_output_pin_out(ref_output_pin_out),
    .ref_output_pin_oe(ref_output_pin_oe),
    .core_clock_source_select(core_clock_source_select),
    .pll_clock_running(pll_clock_running), .pll_locked(pll_locked));

//--- testbench.sv
// register-level testbench for the pll lock and clock output block
`timescale 1ns/1ps
`include "plock_params.svh"

module testbench;
    logic        core_clk, reset, reg_write, reg_read, mclk, mclk_on;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
    logic        pin_out, pin_oe, src_sel, running, locked;
    int          n_mismatch, n_checks, mhalf, mcnt, h;
    int          div_t[5]  = '{0, 0, 1, 0, 0};
    int          mh_t[5]   = '{16, 16, 8, 16, 16};
    int          oc_t[5]   = '{1, 3, 5, 7, 6};
    int          exp_t[5]  = '{16, 8, 4, 2, 0};

    plock_core uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .master_clock_input_pin(mclk),
        .ref_output_pin_out(pin_out), .ref_output_pin_oe(pin_oe),
        .core_clock_source_select(src_sel), .pll_clock_running(running),
        .pll_locked(locked));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // master clock held still while stopped
    always @(posedge core_clk) begin
        if (mclk_on) begin
            if (mcnt >= mhalf - 1) begin
                mcnt <= 0;
                mclk <= ~mclk;
            end else mcnt <= mcnt + 1;
        end
    end

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task wait_lock();
        v = 16'h0000;
        for (int k = 0; k < 100 && v !== 16'h0001; k++) begin
            rd(`PLOCK_ADDR_LOCK, v);
            if (v !== 16'h0001) repeat (20) @(posedge core_clk);
        end
    endtask : wait_lock

    // cycles between two successive output pin transitions
    task half_period(output int n);
        logic p;
        n = 0;
        @(posedge core_clk); #1 p = pin_out;
        while (pin_out === p && n < 200) begin @(posedge core_clk); #1 n++; end
        p = pin_out; n = 0;
        while (pin_out === p && n < 200) begin @(posedge core_clk); #1 n++; end
    endtask : half_period

    task test_done();
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial begin
        #300000;
        n_mismatch++;
        test_done();
    end

    initial begin
        n_mismatch = 0; n_checks = 0; reset = 1'b1; reg_write = 1'b0;
        reg_read = 1'b0; reg_addr = 16'h0000; reg_wdata = 16'h0000;
        mclk = 1'b0; mclk_on = 1'b1; mhalf = 16; mcnt = 0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(`PLOCK_ADDR_LOCK, v);   cmp(v, 16'h0000);
        rd(`PLOCK_ADDR_OUTCTL, v); cmp(v, 16'h0000);
        rd(16'hf010, v);           cmp(v, 16'h0000);
        wr(`PLOCK_ADDR_LOCK, 16'h0001);
        rd(`PLOCK_ADDR_LOCK, v);   cmp(v, 16'h0000);
        wr(`PLOCK_ADDR_OUTCTL, 16'h0007);
        rd(`PLOCK_ADDR_OUTCTL, v); cmp(v, 16'h0007);
        cmp(pin_oe, 1'b0);
        wr(`PLOCK_ADDR_ENABLE, 16'h0001);
        repeat (800) @(posedge core_clk);
        rd(`PLOCK_ADDR_LOCK, v);   cmp(v, 16'h0000);
        wr(`PLOCK_ADDR_ENABLE, 16'h0000);
        wr(`PLOCK_ADDR_CONFIG_A, 16'h0001);
        wr(`PLOCK_ADDR_SOURCE, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            wr(`PLOCK_ADDR_CONFIG_B, div_t[i][15:0]);
            wr(`PLOCK_ADDR_OUTCTL, oc_t[i][15:0]);
            mhalf = mh_t[i];
            wr(`PLOCK_ADDR_ENABLE, 16'h0001);
            #1 cmp(src_sel, 1'b1);
            wait_lock(); cmp(v, 16'h0001);
            cmp(locked, 1'b1);
            cmp(running, 1'b1);
            cmp(pin_oe, exp_t[i] != 0);
            if (exp_t[i] != 0) begin
                half_period(h); cmp(h[15:0], exp_t[i][15:0]);
            end
            wr(`PLOCK_ADDR_OUTCTL, 16'h0000);
            repeat (4) @(posedge core_clk);
            cmp(pin_oe, exp_t[i] != 0);
            wr(`PLOCK_ADDR_ENABLE, 16'h0000);
            #1 cmp(running, 1'b0);
            cmp(locked, 1'b0);
            rd(`PLOCK_ADDR_LOCK, v); cmp(v, 16'h0000);
        end
        wr(`PLOCK_ADDR_OUTCTL, 16'h0001);
        wr(`PLOCK_ADDR_ENABLE, 16'h0001);
        wait_lock(); cmp(v, 16'h0001);
        mclk_on <= 1'b0;
        repeat (1100) @(posedge core_clk);
        rd(`PLOCK_ADDR_LOCK, v); cmp(v, 16'h0000);
        test_done();
    end
endmodule : testbench
